// ===== common/qdcd_pkg.sv
// Package of constants for the quad DAC command decoder.
package qdcd_pkg;
  localparam int DATA_W = 12;
  localparam int NCH = 4;
  localparam logic [3:0] CMD_XFER = 4'hE;
  localparam logic [3:0] CMD_LOAD_ALL_UPD = 4'hC;
  localparam logic [3:0] CMD_LOAD_ALL = 4'hD;
  localparam logic [3:0] CMD_EXT = 4'hF;
  localparam int CMD_POS = 4;
  localparam int EXT_CH_POS = 4;
  localparam int PD_SEL_HIGH_POS = 1;
  localparam int PD_SEL_LOW_POS = 0;
  localparam logic [1:0] PD_RESET = 2'h0;
  localparam logic [11:0] DATA_RESET = 12'h000;
  localparam logic [1:0] SEL_RESET = 2'h0;
endpackage

// ===== design/qdcd_channel.sv
// One double-buffered DAC channel: input register and output register.
`timescale 1ns/1ns
module qdcd_channel (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Load controls.
  input wire logic load_in,
  input wire logic load_out_new,
  input wire logic xfer,
  input wire logic [11:0] new_data,
  // Register contents.
  output logic [11:0] in_reg,
  output logic [11:0] out_reg
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_reg <= qdcd_pkg::DATA_RESET;
    end else if (load_in) begin
      in_reg <= new_data;
    end
  end

  // Output load with new data beats a transfer of the old input value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= qdcd_pkg::DATA_RESET;
    end else if (load_out_new) begin
      out_reg <= new_data;
    end else if (xfer) begin
      out_reg <= in_reg;
    end
  end
endmodule

// ===== design/qdcd_decoder.sv
// Command decoder for the quad 12-bit DAC: decodes write bytes and steers data to channels.
`timescale 1ns/1ns
module qdcd_decoder (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Received write bytes from the serial front end.
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic FIRST_BYTE,
  input wire logic ACK_EDGE,
  input wire logic ABORT,
  // Read-back byte request from the front end.
  input wire logic RD_REQ,
  input wire logic RD_ACKED,
  // Channel outputs.
  output logic [11:0] DAC_A,
  output logic [11:0] DAC_B,
  output logic [11:0] DAC_C,
  output logic [11:0] DAC_D,
  // Power-down state.
  output logic [3:0] PD_CH,
  output logic [1:0] PD_MODE,
  // Read-back.
  output logic [7:0] RD_BYTE,
  output logic RD_SECOND,
  output logic [1:0] RD_SEL
);
  localparam int NCH_L = qdcd_pkg::NCH;
  typedef enum {QDCD_IDLE, QDCD_LOW, QDCD_EXTB, QDCD_SKIP} qdcd_state_t;
  qdcd_state_t state;
  logic [3:0] cmd;
  logic [3:0] nib;
  logic [NCH_L-1:0] ld_in;
  logic [NCH_L-1:0] ld_out;
  logic [11:0] in_q [4];
  logic [11:0] out_q [4];
  logic [11:0] new_word;
  logic commit;
  logic xfer_all;
  logic [1:0] sel;

  assign new_word = {nib, BYTE_DATA};
  assign commit = ACK_EDGE && BYTE_VALID && !ABORT;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= QDCD_IDLE;
      cmd <= 4'h0;
      nib <= 4'h0;
    end else if (ABORT) begin
      state <= QDCD_IDLE;
    end else if (commit) begin
      if (FIRST_BYTE || state == QDCD_IDLE) begin
        cmd <= BYTE_DATA[7:4];
        nib <= BYTE_DATA[3:0];
        case (BYTE_DATA[7:4])
          qdcd_pkg::CMD_XFER: begin
            state <= QDCD_IDLE;
          end
          qdcd_pkg::CMD_EXT: begin
            if (BYTE_DATA[3:0] == 4'h0) begin
              state <= QDCD_EXTB;
            end else begin
              state <= QDCD_IDLE;
            end
          end
          default: begin
            state <= QDCD_LOW;
          end
        endcase
      end else begin
        state <= QDCD_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ld_in = 4'h0;
    ld_out = 4'h0;
    xfer_all = 1'b0;
    if (commit && !FIRST_BYTE && state == QDCD_LOW) begin
      case (cmd[3:2])
        2'h0: begin
          ld_in[cmd[1:0]] = 1'b1;
          ld_out[cmd[1:0]] = 1'b1;
          xfer_all = 1'b1;
        end
        2'h1: begin
          ld_in[cmd[1:0]] = 1'b1;
        end
        2'h2: begin
          ld_in[cmd[1:0]] = 1'b1;
          xfer_all = 1'b1;
        end
        default: begin
          if (cmd == qdcd_pkg::CMD_LOAD_ALL_UPD) begin
            ld_in = 4'hF;
            ld_out = 4'hF;
          end else if (cmd == qdcd_pkg::CMD_LOAD_ALL) begin
            ld_in = 4'hF;
          end
        end
      endcase
    end
    if (commit && (FIRST_BYTE || state == QDCD_IDLE) && BYTE_DATA[7:4] == qdcd_pkg::CMD_XFER) begin
      xfer_all = 1'b1;
    end
  end

  for (genvar i = 0; i < NCH_L; i++) begin : g_ch
    qdcd_channel u_ch (
      .clk(MCLK),
      .rst_n(RST_N),
      .load_in(ld_in[i]),
      .load_out_new(ld_out[i]),
      .xfer(xfer_all),
      .new_data(new_word),
      .in_reg(in_q[i]),
      .out_reg(out_q[i])
    );
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      DAC_A <= qdcd_pkg::DATA_RESET;
      DAC_B <= qdcd_pkg::DATA_RESET;
      DAC_C <= qdcd_pkg::DATA_RESET;
      DAC_D <= qdcd_pkg::DATA_RESET;
    end else begin
      DAC_A <= out_q[0];
      DAC_B <= out_q[1];
      DAC_C <= out_q[2];
      DAC_D <= out_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels not flagged return to normal operation, since each write rewrites the whole set.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PD_CH <= 4'h0;
      PD_MODE <= qdcd_pkg::PD_RESET;
    end else if (commit && !FIRST_BYTE && state == QDCD_EXTB) begin
      PD_CH <= BYTE_DATA[qdcd_pkg::EXT_CH_POS +: 4];
      PD_MODE <= {BYTE_DATA[qdcd_pkg::PD_SEL_HIGH_POS], BYTE_DATA[qdcd_pkg::PD_SEL_LOW_POS]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back channel select
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sel <= qdcd_pkg::SEL_RESET;
    end else if (commit && (FIRST_BYTE || state == QDCD_IDLE) && BYTE_DATA[7:4] == qdcd_pkg::CMD_EXT) begin
      case (BYTE_DATA[3:0])
        4'h1: sel <= 2'h0;
        4'h2: sel <= 2'h1;
        4'h4: sel <= 2'h2;
        4'h8: sel <= 2'h3;
        default: sel <= sel;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RD_SECOND <= 1'b0;
      RD_BYTE <= 8'h00;
      RD_SEL <= qdcd_pkg::SEL_RESET;
    end else begin
      RD_SEL <= sel;
      if (RD_REQ) begin
        RD_SECOND <= 1'b0;
        RD_BYTE <= {4'h0, out_q[sel][11:8]};
      end else if (RD_ACKED && !RD_SECOND) begin
        RD_SECOND <= 1'b1;
        RD_BYTE <= out_q[sel][7:0];
      end
    end
  end

  // Assertions.
  xfer_cmd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && FIRST_BYTE && BYTE_DATA[7:4] == qdcd_pkg::CMD_XFER) |=> (out_q[0] == $past(in_q[0])))
    else $error("Transfer command did not move input to output.");
  abort_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ABORT |-> (ld_in == 4'h0 && ld_out == 4'h0 && !xfer_all) ##1 ($stable(out_q[1]) && $stable(in_q[1])))
    else $error("Abort changed a register.");
  pd_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && !FIRST_BYTE && state == QDCD_EXTB) |=> (PD_CH == $past(BYTE_DATA[7:4])))
    else $error("Power-down write not taken.");
  in_only_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && !FIRST_BYTE && state == QDCD_LOW && cmd[3:2] == 2'h1) |=> $stable(out_q[2]))
    else $error("Input-only load moved an output.");
  bcast_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && !FIRST_BYTE && state == QDCD_LOW && cmd == qdcd_pkg::CMD_LOAD_ALL_UPD)
    |=> (out_q[3] == $past(new_word) && in_q[0] == $past(new_word)))
    else $error("Broadcast load did not update outputs.");
  xfer_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (commit && !FIRST_BYTE && state == QDCD_LOW && cmd[3:2] == 2'h2)
    |=> (out_q[0] == $past(in_q[0]) && out_q[3] == $past(in_q[3]) && in_q[cmd[1:0]] == $past(new_word)))
    else $error("Transfer-then-load command moved the wrong values.");

  // Extended mode needs two bytes; the command byte only arms the configuration write.
  sequence ext_entry_s;
    commit && (FIRST_BYTE || state == QDCD_IDLE) && BYTE_DATA[7:4] == qdcd_pkg::CMD_EXT && BYTE_DATA[3:0] == 4'h0;
  endsequence
  ext_entry_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ext_entry_s |=> (state == QDCD_EXTB && sel == $past(sel)))
    else $error("Extended command byte did not arm the configuration write.");
endmodule

// ===== sim/qdcd_master_model.sv
// Bus master model that hands write bytes and read-back strobes to the decoder.
`timescale 1ns/1ns
module qdcd_master_model (
  // Clock.
  input wire logic clk,
  // Write byte side.
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic first_byte,
  output logic ack_edge,
  output logic abort,
  // Read-back strobes.
  output logic rd_req,
  output logic rd_acked
);
  initial {byte_valid, byte_data, first_byte, ack_edge, abort, rd_req, rd_acked} = '0;
  // Whole bytes only
  // A released bus shows the inverse of the last byte, so stale data cannot pass.
  task automatic put(input logic [7:0] b, input logic first, input logic abt);
    @(negedge clk);
    {byte_valid, byte_data, first_byte, ack_edge, abort} = {1'b1, b, first, 1'b1, abt};
    @(negedge clk);
    {byte_valid, byte_data, first_byte, ack_edge, abort} = {1'b0, ~b, 3'h0};
  endtask
  task automatic strobe(input logic ack);
    @(negedge clk);
    {rd_req, rd_acked} = {~ack, ack};
    @(negedge clk);
    {rd_req, rd_acked} = 2'h0;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the quad DAC command decoder.
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic bv, fb, ae, ab, rq, ra, rd_second;
  logic [7:0] bd, rd_byte, b;
  logic [11:0] dac [4];
  logic [11:0] in_m [4];
  logic [11:0] out_m [4];
  logic [3:0] pd_ch, c;
  logic [1:0] pd_mode, rd_sel;
  logic [11:0] d;
  integer seed = 32'hBDEB;
  int fail_count = 0;
  int comparisons = 0;
  qdcd_master_model i_qdcd_master_model (.clk(mclk), .byte_valid(bv), .byte_data(bd), .first_byte(fb),
    .ack_edge(ae), .abort(ab), .rd_req(rq), .rd_acked(ra));
  qdcd_decoder i_qdcd_decoder (.MCLK(mclk), .RST_N(rst_n), .BYTE_VALID(bv), .BYTE_DATA(bd), .FIRST_BYTE(fb),
    .ACK_EDGE(ae), .ABORT(ab), .RD_REQ(rq), .RD_ACKED(ra), .DAC_A(dac[0]), .DAC_B(dac[1]), .DAC_C(dac[2]),
    .DAC_D(dac[3]), .PD_CH(pd_ch), .PD_MODE(pd_mode), .RD_BYTE(rd_byte), .RD_SECOND(rd_second), .RD_SEL(rd_sel));
  initial forever #20 mclk = ~mclk;
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_dacs();
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 4; i++) cmp(dac[i], out_m[i]);
  endtask
  // The expected register image after one write command.
  task automatic model(input logic [3:0] k, input logic [11:0] v);
    if (k[3:2] != 2'h1 && (k[3] == 1'b0 || k[2] == 1'b0 || k == qdcd_pkg::CMD_XFER)) out_m = in_m;
    if (k[3:2] != 2'h3) in_m[k[1:0]] = v;
    if (k[3:2] == 2'h0) out_m[k[1:0]] = v;
    if (k == qdcd_pkg::CMD_LOAD_ALL_UPD || k == qdcd_pkg::CMD_LOAD_ALL) in_m = '{v, v, v, v};
    if (k == qdcd_pkg::CMD_LOAD_ALL_UPD) out_m = in_m;
  endtask
  task automatic wr(input logic [3:0] k, input logic [11:0] v);
    i_qdcd_master_model.put({k, v[11:8]}, 1'b1, 1'b0);
    if (k != qdcd_pkg::CMD_XFER) i_qdcd_master_model.put(v[7:0], 1'b0, 1'b0);
    model(k, v);
    chk_dacs();
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    in_m = '{4{qdcd_pkg::DATA_RESET}};
    out_m = in_m;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    chk_dacs();
    wr(4'hC, 12'hFFF);
    wr(4'hD, 12'h000);
    wr(4'hE, 12'hA5A);
    wr(4'h0, 12'h123);
    wr(4'h7, 12'h456);
    wr(4'hB, 12'h789);
    for (int i = 0; i < 60; i++) begin
      c = 4'($unsigned($random(seed)) % 15);
      d = 12'($random(seed));
      wr(c, d);
    end
    i_qdcd_master_model.put(8'h07, 1'b1, 1'b0);
    i_qdcd_master_model.put(8'hA5, 1'b0, 1'b1);
    wr(4'hE, 12'h000);
    i_qdcd_master_model.put(8'hF3, 1'b1, 1'b0);
    chk_dacs();
    cmp(12'(pd_ch), 12'h0);
    cmp(12'(rd_sel), 12'h0);
    for (int m = 0; m < 4; m++) begin
      b = 8'($random(seed));
      b[1:0] = 2'(m);
      i_qdcd_master_model.put(8'hF0, 1'b1, 1'b0);
      i_qdcd_master_model.put(b, 1'b0, 1'b0);
      chk_dacs();
      cmp(12'(pd_ch), 12'(b[7:4]));
      cmp(12'(pd_mode), 12'(m));
    end
    for (int i = 0; i < 4; i++) begin
      i_qdcd_master_model.put({4'hF, 4'(1 << i)}, 1'b1, 1'b0);
      chk_dacs();
      cmp(12'(rd_sel), 12'(i));
      i_qdcd_master_model.strobe(1'b0);
      repeat (2) @(negedge mclk);
      cmp(12'(rd_byte), {8'h00, out_m[i][11:8]});
      cmp(12'(rd_second), 12'h0);
      i_qdcd_master_model.strobe(1'b1);
      repeat (2) @(negedge mclk);
      cmp(12'(rd_byte), {4'h0, out_m[i][7:0]});
      cmp(12'(rd_second), 12'h1);
    end
    give_verdict();
  end
endmodule
